/* rtl/sesr_defs.svh */
// register offsets, codes, field positions and reset values of the nv shadow block
`ifndef SESR_DEFS_SVH
`define SESR_DEFS_SVH
// register indices; byte address is four times the index
`define SESR_IDX_CMD 10'h000
`define SESR_IDX_KEY3 10'h0B0
`define SESR_IDX_KEY2 10'h0B1
`define SESR_IDX_KEY1 10'h0B2
`define SESR_IDX_KEY0 10'h0B3
`define SESR_IDX_RES 10'h0D0
`define SESR_IDX_STAT 10'h0F9
`define SESR_IDX_IST 10'h100
`define SESR_IDX_ICLR 10'h101
`define SESR_IDX_IEN 10'h102
`define SESR_IDX_RAM_LO 10'h200
`define SESR_IDX_RAM_HI 10'h3CF
// codes
`define SESR_KEY 32'hA53C0F5A
`define SESR_CMD_SAVE 6'h15
`define SESR_CMD_REST 6'h16
`define SESR_RES_PASS 8'h00
`define SESR_RES_FAIL 8'hFF
// command register fields
`define SESR_CMD_GO 7
`define SESR_CMD_DONE 6
// status bits
`define SESR_ST_ECCUSED 0
`define SESR_ST_ECCFAIL 1
`define SESR_ST_PROGFAIL 2
`define SESR_ST_CKERR 3
// interrupt status bits
`define SESR_IRQ_SAVE 0
`define SESR_IRQ_REST 1
`define SESR_IRQ_ERR 2
// reset values
`define SESR_RST_CMD 8'h00
`define SESR_RST_STAT 4'h0
`define SESR_RST_IRQ 3'h0
`endif

/* rtl/sesr_pkg.sv */
// types shared by the nv shadow save/restore block
package sesr_pkg;
  typedef enum logic [1:0] {
    SESR_IDLE = 2'b00,
    SESR_SAVE = 2'b01,
    SESR_REST = 2'b11,
    SESR_FIN = 2'b10
  } sesr_state_t;

  // stored word: overall parity in bit 0, hamming code above
  typedef struct packed {
    logic [38:0] cw;
  } sesr_nvword_t;

  typedef struct packed {
    logic [31:0] data;
    logic corr;
    logic fail;
  } sesr_dec_t;
endpackage

/* rtl/sesr_top.sv */
// nv shadow save/restore controller with wishbone register slave
// Operation
// - 464 bytes nv storage mirror user ram segment 0x200 to 0x3CF.
// - key 0xA53C0F5A in bytes 0x0B0-0x0B3, msb first, needed for commands.
// - each stored 32-bit word has secded ecc: fix one, detect two flips.
// - 32-bit checksum over stored image, verified on restore, mismatch flagged.
// - writing 0x95 to command register 0x000 saves user ram to nv.
// - writing 0x96 to command register restores nv image to user ram.
// - on finish: completion pin high, go flag cleared, done flag set.
// - restore result 0x0D0 reads 0x00 on pass, 0xFF on fail.
// - status bit 2 set when programming a location fails.
// - restore sets bit 0 on corrected word, bit 1 on uncorrectable word.
// - restore sets status bit 3 on checksum mismatch.
// - status sticky; cleared by writing 0x00, reset, or sleep exit.
`timescale 1ns/1ps
`include "sesr_defs.svh"
module sesr_top #(
  parameter int NV_WORDS = 128,
  parameter int RAM_BYTES = 464
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic sleep_exit_i, // pulse on leaving sleep
  input wire logic [38:0] nv_err_inj_i, // flips bits of words as stored
  output logic done_o, // completion pin
  output logic irq_o // level interrupt
);
  import sesr_pkg::*;
  localparam int WORDS = RAM_BYTES / 4;
  localparam logic [6:0] LAST = 7'(WORDS);

  // ----------------------------------------------------------------
  // ecc helpers
  // ----------------------------------------------------------------
  function automatic sesr_nvword_t ecc_enc(input logic [31:0] d);
    logic [38:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p < 39; p++)
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = d[k];
        k++;
      end
    for (int b = 0; b < 6; b++)
      for (int p = 1; p < 39; p++)
        if (p[b] && (p != (1 << b)))
          cw[1 << b] = cw[1 << b] ^ cw[p];
    cw[0] = ^cw[38:1];
    return '{cw: cw};
  endfunction

  function automatic sesr_dec_t ecc_dec(input sesr_nvword_t w);
    logic [38:0] cw;
    logic [5:0] syn;
    logic ov;
    sesr_dec_t r;
    int k;
    cw = w.cw;
    syn = '0;
    r = '0;
    k = 0;
    for (int p = 1; p < 39; p++)
      if (cw[p])
        syn = syn ^ 6'(p);
    ov = ^cw;
    r.corr = ov && (syn < 6'd39);
    r.fail = ov ? (syn >= 6'd39) : (syn != 6'd0);
    if (r.corr)
      cw[syn] = ~cw[syn];
    for (int p = 1; p < 39; p++)
      if ((p & (p - 1)) != 0)
      begin
        r.data[k] = cw[p];
        k++;
      end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] uram [0:RAM_BYTES-1];
  sesr_nvword_t nvmem [0:NV_WORDS-1];
  sesr_state_t state_reg, state_next;
  logic [6:0] widx_reg, widx_next;
  logic [31:0] sum_reg, sum_next;
  logic rest_reg, rest_next;
  logic keyok_reg, keyok_next;
  logic fail_reg, fail_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] key_reg [0:3];
  logic [7:0] key_next [0:3];
  logic [7:0] res_reg, res_next;
  logic [3:0] stat_reg, stat_next;
  logic [2:0] ist_reg, ist_next;
  logic [2:0] ien_reg, ien_next;
  logic ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic irq_reg, irq_next;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req, wr, rd, in_ram, busy;
  logic [9:0] idx, ram_off;
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign idx = wb_adr_i[11:2];
  assign in_ram = (idx >= `SESR_IDX_RAM_LO) && (idx <= `SESR_IDX_RAM_HI);
  assign ram_off = idx - `SESR_IDX_RAM_LO;
  assign busy = state_reg != SESR_IDLE;
  function automatic logic [31:0] rd_word(input logic [9:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      `SESR_IDX_CMD: v[7:0] = cmd_reg;
      `SESR_IDX_KEY3: v[7:0] = key_reg[3];
      `SESR_IDX_KEY2: v[7:0] = key_reg[2];
      `SESR_IDX_KEY1: v[7:0] = key_reg[1];
      `SESR_IDX_KEY0: v[7:0] = key_reg[0];
      `SESR_IDX_RES: v[7:0] = res_reg;
      `SESR_IDX_STAT: v[3:0] = stat_reg;
      `SESR_IDX_IST: v[2:0] = ist_reg;
      `SESR_IDX_IEN: v[2:0] = ien_reg;
      default: v = '0; // unmapped and write-only read zero
    endcase
    return v;
  endfunction

  // word sequencer datapath
  logic [31:0] ram_word, key_word;
  sesr_nvword_t enc_w, wr_w;
  sesr_dec_t dec_w;
  logic [8:0] base;
  logic start, keymatch;
  assign base = {widx_reg, 2'b00};
  assign ram_word = (widx_reg < LAST) ?
    {uram[base], uram[base + 9'd1], uram[base + 9'd2], uram[base + 9'd3]} : sum_reg;
  assign enc_w = ecc_enc(ram_word);
  assign wr_w = '{cw: enc_w.cw ^ nv_err_inj_i};
  assign dec_w = ecc_dec(nvmem[widx_reg]);
  assign key_word = {key_reg[3], key_reg[2], key_reg[1], key_reg[0]};
  assign keymatch = key_word == `SESR_KEY;
  assign start = wr && (idx == `SESR_IDX_CMD) && !busy && wb_dat_i[`SESR_CMD_GO];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    widx_next = widx_reg;
    sum_next = sum_reg;
    rest_next = rest_reg;
    keyok_next = keyok_reg;
    fail_next = fail_reg;
    cmd_next = cmd_reg;
    key_next = key_reg;
    res_next = res_reg;
    ist_next = ist_reg;
    ien_next = ien_reg;
    stat_next = stat_reg;
    // status clears on sleep exit or a write of zero; set below wins
    if (sleep_exit_i || (wr && idx == `SESR_IDX_STAT && wb_dat_i[7:0] == 8'h00))
      stat_next = `SESR_RST_STAT;
    if (wr && idx == `SESR_IDX_ICLR)
      ist_next = ist_next & ~wb_dat_i[2:0];
    if (wr && idx == `SESR_IDX_IEN)
      ien_next = wb_dat_i[2:0];
    if (wr && !busy)
    begin
      for (int i = 0; i < 4; i++)
        if (idx == `SESR_IDX_KEY0 - 10'(i))
          key_next[i] = wb_dat_i[7:0];
      if (idx == `SESR_IDX_CMD)
        cmd_next = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
    end
    unique case (state_reg)
      SESR_IDLE:
      begin
        widx_next = '0;
        sum_next = '0;
        if (start)
        begin
          keyok_next = keymatch;
          fail_next = 1'b0;
          rest_next = wb_dat_i[5:0] == `SESR_CMD_REST;
          if (!keymatch)
            state_next = SESR_FIN;
          else if (wb_dat_i[5:0] == `SESR_CMD_SAVE)
            state_next = SESR_SAVE;
          else if (wb_dat_i[5:0] == `SESR_CMD_REST)
            state_next = SESR_REST;
          else
            state_next = SESR_FIN;
        end
      end
      SESR_SAVE:
      begin
        // written value is checked against the intended code word
        if (wr_w != enc_w)
        begin
          stat_next[`SESR_ST_PROGFAIL] = 1'b1;
          fail_next = 1'b1;
        end
        sum_next = sum_reg + ram_word;
        widx_next = widx_reg + 7'd1;
        if (widx_reg == LAST)
          state_next = SESR_FIN;
      end
      SESR_REST:
      begin
        if (dec_w.corr)
          stat_next[`SESR_ST_ECCUSED] = 1'b1;
        if (dec_w.fail)
        begin
          stat_next[`SESR_ST_ECCFAIL] = 1'b1;
          fail_next = 1'b1;
        end
        widx_next = widx_reg + 7'd1;
        if (widx_reg == LAST)
        begin
          if (dec_w.data != sum_reg)
          begin
            stat_next[`SESR_ST_CKERR] = 1'b1;
            fail_next = 1'b1;
          end
          state_next = SESR_FIN;
        end
        else
          sum_next = sum_reg + dec_w.data;
      end
      SESR_FIN:
      begin
        cmd_next[`SESR_CMD_GO] = 1'b0;
        cmd_next[`SESR_CMD_DONE] = 1'b1;
        if (rest_reg)
        begin
          res_next = (fail_reg || !keyok_reg) ? `SESR_RES_FAIL : `SESR_RES_PASS;
          ist_next[`SESR_IRQ_REST] = 1'b1;
        end
        else
          ist_next[`SESR_IRQ_SAVE] = 1'b1;
        if (fail_reg || !keyok_reg)
          ist_next[`SESR_IRQ_ERR] = 1'b1;
        state_next = SESR_IDLE;
      end
    endcase
    ack_next = req;
    rd_next = rd ? rd_word(idx) : '0;
    if (rd && in_ram)
      rd_next = {24'h000000, uram[ram_off[8:0]]};
    irq_next = |(ist_next & ien_next);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= SESR_IDLE;
      widx_reg <= '0;
      sum_reg <= '0;
      rest_reg <= 1'b0;
      keyok_reg <= 1'b0;
      fail_reg <= 1'b0;
      cmd_reg <= `SESR_RST_CMD;
      key_reg <= '{default: 8'h00};
      res_reg <= `SESR_RES_PASS;
      stat_reg <= `SESR_RST_STAT;
      ist_reg <= `SESR_RST_IRQ;
      ien_reg <= `SESR_RST_IRQ;
      ack_reg <= 1'b0;
      rd_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      widx_reg <= widx_next;
      sum_reg <= sum_next;
      rest_reg <= rest_next;
      keyok_reg <= keyok_next;
      fail_reg <= fail_next;
      cmd_reg <= cmd_next;
      key_reg <= key_next;
      res_reg <= res_next;
      stat_reg <= stat_next;
      ist_reg <= ist_next;
      ien_reg <= ien_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
      irq_reg <= irq_next;
    end
  end

  // memories: no reset, contents survive like the real cells
  always_ff @(posedge clk_i)
  begin
    if (state_reg == SESR_SAVE)
      nvmem[widx_reg] <= wr_w;
    if (state_reg == SESR_REST && widx_reg < LAST)
    begin
      for (int j = 0; j < 4; j++)
        uram[base + 9'(j)] <= dec_w.data[31 - 8*j -: 8];
    end
    else if (wr && in_ram && !busy)
      uram[ram_off[8:0]] <= wb_dat_i[7:0];
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign done_o = cmd_reg[`SESR_CMD_DONE];
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
  property p_stat_hi;
    @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && !wb_we_i && idx == `SESR_IDX_STAT) |-> wb_dat_o[31:4] == 28'h0;
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status high bits set");
  property p_badkey;
    @(posedge clk_i) disable iff (rst_i)
      (start && !keymatch) |=> state_reg == SESR_FIN ##1 state_reg == SESR_IDLE;
  endproperty
  a_badkey: assert property (p_badkey) else $error("bad key not refused");
  property p_save_len;
    @(posedge clk_i) disable iff (rst_i)
      (start && keymatch && wb_dat_i[5:0] == `SESR_CMD_SAVE)
      |=> (state_reg == SESR_SAVE)[*8];
  endproperty
  a_save_len: assert property (p_save_len) else $error("save ended early");
  property p_done;
    @(posedge clk_i) disable iff (rst_i)
      state_reg == SESR_FIN |=> done_o && !cmd_reg[`SESR_CMD_GO];
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");
  property p_result;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == SESR_FIN && rest_reg && !fail_reg && keyok_reg)
      |=> res_reg == `SESR_RES_PASS;
  endproperty
  a_result: assert property (p_result) else $error("result code wrong");
  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (stat_reg != 4'h0 && !sleep_exit_i && !(wr && idx == `SESR_IDX_STAT))
      |=> (stat_reg & $past(stat_reg)) == $past(stat_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
  property p_eccfail;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == SESR_REST && dec_w.fail) |=> stat_reg[`SESR_ST_ECCFAIL];
  endproperty
  a_eccfail: assert property (p_eccfail) else $error("ecc failure not flagged");
  property p_progfail;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == SESR_SAVE && wr_w != enc_w) |=> stat_reg[`SESR_ST_PROGFAIL];
  endproperty
  a_progfail: assert property (p_progfail) else $error("program failure lost");
  property p_ckerr;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg == SESR_REST && widx_reg == LAST && dec_w.data != sum_reg)
      |=> stat_reg[`SESR_ST_CKERR] ##1 res_reg == `SESR_RES_FAIL;
  endproperty
  a_ckerr: assert property (p_ckerr) else $error("checksum error missed");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i) irq_o |-> (ist_reg & ien_reg) != 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without source");

  c_save: cover property (@(posedge clk_i) state_reg == SESR_SAVE ##1 state_reg == SESR_FIN);
  c_rest: cover property (@(posedge clk_i) state_reg == SESR_REST ##1 state_reg == SESR_FIN);
  c_corr: cover property (@(posedge clk_i) stat_reg[`SESR_ST_ECCUSED]);
  c_irq: cover property (@(posedge clk_i) $rose(irq_o));
endmodule

/* verification/sesr_host.sv */
// wishbone host model: register cycles, key load and commands
`timescale 1ns/1ps
`include "sesr_defs.svh"
module sesr_host (
  input wire logic clk_i, // clock
  input wire logic [31:0] wb_dat_i, // read data from slave
  input wire logic wb_ack_i, // slave acknowledge
  input wire logic done_i, // completion pin
  output logic wb_cyc_o, // cycle
  output logic wb_stb_o, // strobe
  output logic wb_we_o, // write enable
  output logic [11:0] wb_adr_o, // byte address
  output logic [3:0] wb_sel_o, // byte lanes
  output logic [31:0] wb_dat_o // write data
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 12'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // request held until ack is sampled; released data shows its inverse
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_sel_o <= 4'hF;
    wb_dat_o <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_dat_o <= ~{24'h0, d};
  endtask

  task automatic load_key(input logic [31:0] k);
    logic [31:0] q;
    for (int i = 0; i < 4; i++)
      xfer(1'b1, `SESR_IDX_KEY3 + 10'(i), k[31 - 8 * i -: 8], q);
  endtask

  // waits up to 400 cycles for completion before the host goes on
  task automatic run_cmd(input logic [7:0] c, output bit ok);
    logic [31:0] q;
    xfer(1'b1, `SESR_IDX_CMD, c, q);
    for (int n = 0; n < 400 && done_i !== 1'b1; n++) @(posedge clk_i);
    ok = (done_i === 1'b1);
  endtask
endmodule

/* verification/tb_sesr_top.sv */
// self-checking bench of the nv shadow save/restore block
`timescale 1ns/1ps
`include "sesr_defs.svh"
module tb_sesr_top;
  import sesr_pkg::*;
  logic clk_i, rst_i, sleep_exit_i, wb_cyc, wb_stb, wb_we, wb_ack, done_o, irq_o;
  logic [38:0] nv_err_inj_i;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [7:0] img [116];
  int n_fail = 0;
  int total_checks = 0;
  int a;
  bit ok;

  sesr_top sesr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sleep_exit_i(sleep_exit_i),
    .nv_err_inj_i(nv_err_inj_i), .done_o(done_o), .irq_o(irq_o));
  sesr_host sesr_host_i (.clk_i(clk_i), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack),
    .done_i(done_o), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat));

  function automatic logic [7:0] exp_done(input logic [5:0] code);
    return 8'h40 | {2'b00, code};
  endfunction

  task automatic fail(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e, input string m);
    sesr_host_i.xfer(1'b0, idx, 8'h00, q);
    total_checks++;
    if (q !== {24'h0, e})
      fail(m);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    sesr_host_i.xfer(1'b1, idx, d, q);
  endtask

  task automatic cmd(input logic [7:0] c);
    sesr_host_i.load_key(`SESR_KEY);
    sesr_host_i.run_cmd(c, ok);
    total_checks++;
    if (!ok)
      fail("no completion");
  endtask

  task automatic fill_ram(input bit inv);
    for (int i = 0; i < 116; i++)
      wr(`SESR_IDX_RAM_LO + 10'(i), inv ? ~img[i] : img[i]);
  endtask

  task automatic chk_ram(input bit inv);
    for (int i = 0; i < 116; i++)
      rd_chk(`SESR_IDX_RAM_LO + 10'(i), inv ? ~img[i] : img[i], "ram data");
  endtask

  task automatic chk_irq(input logic e);
    total_checks++;
    if (irq_o !== e)
      fail("irq level");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (30000) @(posedge clk_i);
    fail("timeout");
    complete_run();
  end

  initial
  begin
    rst_i = 1'b1;
    sleep_exit_i = 1'b0;
    nv_err_inj_i = 39'h0;
    q = $urandom(32'h90e6);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`SESR_IDX_CMD, `SESR_RST_CMD, "cmd reset");
    rd_chk(`SESR_IDX_STAT, 8'h00, "status reset");
    rd_chk(`SESR_IDX_RES, `SESR_RES_PASS, "result reset");
    rd_chk(10'h050, 8'h00, "unmapped read");
    // clean save, interrupt enabled for save only
    for (int i = 0; i < 116; i++)
      img[i] = 8'($urandom);
    fill_ram(1'b0);
    wr(`SESR_IDX_IEN, 8'h01);
    cmd(8'h95);
    rd_chk(`SESR_IDX_CMD, exp_done(`SESR_CMD_SAVE), "save flags");
    chk_irq(1'b1);
    rd_chk(`SESR_IDX_STAT, 8'h00, "save status");
    wr(`SESR_IDX_ICLR, 8'h01);
    rd_chk(`SESR_IDX_IST, 8'h00, "irq clear");
    chk_irq(1'b0);
    // scrambled ram is brought back by restore; masked event keeps irq low
    fill_ram(1'b1);
    cmd(8'h96);
    rd_chk(`SESR_IDX_CMD, exp_done(`SESR_CMD_REST), "restore flags");
    rd_chk(`SESR_IDX_RES, `SESR_RES_PASS, "restore pass");
    rd_chk(`SESR_IDX_IST, 8'h02, "irq status");
    chk_irq(1'b0);
    chk_ram(1'b0);
    // one flipped bit per stored word
    @(posedge clk_i);
    nv_err_inj_i <= 39'h1 << $urandom_range(38, 0);
    cmd(8'h95);
    nv_err_inj_i <= 39'h0;
    rd_chk(`SESR_IDX_STAT, 8'h04, "program failure");
    rd_chk(`SESR_IDX_IST, 8'h07, "error event");
    fill_ram(1'b1);
    cmd(8'h96);
    rd_chk(`SESR_IDX_RES, `SESR_RES_PASS, "corrected pass");
    rd_chk(`SESR_IDX_STAT, 8'h05, "ecc used sticky");
    chk_ram(1'b0);
    wr(`SESR_IDX_STAT, 8'hF4);
    rd_chk(`SESR_IDX_STAT, 8'h05, "upper bits");
    wr(`SESR_IDX_STAT, 8'h00);
    rd_chk(`SESR_IDX_STAT, 8'h00, "status clear");
    // two flipped bits per stored word
    a = $urandom_range(38, 0);
    @(posedge clk_i);
    nv_err_inj_i <= (39'h1 << a) | (39'h1 << ((a + 1 + $urandom_range(37, 0)) % 39));
    cmd(8'h95);
    nv_err_inj_i <= 39'h0;
    cmd(8'h96);
    rd_chk(`SESR_IDX_RES, `SESR_RES_FAIL, "uncorrectable fail");
    sesr_host_i.xfer(1'b0, `SESR_IDX_STAT, 8'h00, q);
    total_checks++;
    if (q[2:1] !== 2'b11 || q[7:4] !== 4'h0)
      fail("ecc failure status");
    @(posedge clk_i);
    sleep_exit_i <= 1'b1;
    @(posedge clk_i);
    sleep_exit_i <= 1'b0;
    rd_chk(`SESR_IDX_STAT, 8'h00, "sleep clear");
    // wrong key leaves nv image and ram alone
    fill_ram(1'b0);
    cmd(8'h95);
    fill_ram(1'b1);
    sesr_host_i.load_key(`SESR_KEY ^ 32'h1);
    sesr_host_i.run_cmd(8'h95, ok);
    sesr_host_i.run_cmd(8'h96, ok);
    total_checks++;
    if (!ok)
      fail("bad key no completion");
    rd_chk(`SESR_IDX_RES, `SESR_RES_FAIL, "bad key result");
    chk_ram(1'b1);
    cmd(8'h96);
    rd_chk(`SESR_IDX_RES, `SESR_RES_PASS, "good key result");
    chk_ram(1'b0);
    complete_run();
  end
endmodule
